// ### sim/eqlt_config_regs_properties.sv
// Port checker of the equalizer and loop-through register bank.
`timescale 1ns/1ps
`default_nettype none
`include "eqlt_map.svh"

module eqlt_config_regs_properties
  import eqlt_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic secondPortSelect,
  input wire logic eqAdaptDisable,
  input wire logic [5:0] eqManualSetting,
  input wire logic [3:0] eqFloorPortA,
  input wire logic [3:0] eqFloorPortB,
  input wire logic loopSourceB,
  input wire logic loopSourceValid,
  input wire logic loopDriverOn,
  input wire logic loopTxOff,
  input wire logic patternEnable,
  input wire logic patternBlocked
);
  // Every check runs on the bank clock and is dropped while reset holds.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Write strobes of the registers that the checks follow.
  wire logic wrOvr = regWr && regAddr == `EQLT_ADDR_EQ_OVERRIDE;
  wire logic wrFlr = regWr && regAddr == `EQLT_ADDR_EQ_FLOOR;
  wire logic wrEn = regWr && regAddr == `EQLT_ADDR_LOOP_DRV_EN;
  wire logic wrSelB = regWr && regAddr == `EQLT_ADDR_LOOP_SEL_B;
  wire logic wrPd = regWr && regAddr == `EQLT_ADDR_LOOP_TX_PD;

  a_read_data_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  a_manual_value: assert property (wrOvr && regWdata[0] |-> ##2
    eqAdaptDisable && eqManualSetting == {$past(regWdata[7:5], 2), $past(regWdata[3:1], 2)})
    else $error("manual equalizer setting wrong");
  a_manual_idle: assert property (!eqAdaptDisable |-> eqManualSetting == 6'h00)
    else $error("manual setting applied while adapting");
  a_floor_port_a: assert property (wrFlr && !secondPortSelect |-> ##2
    eqFloorPortA == $past(regWdata[3:0], 2))
    else $error("port A floor wrong");
  a_floor_port_b: assert property (wrFlr && secondPortSelect |-> ##2
    eqFloorPortB == $past(regWdata[3:0], 2) && $stable(eqFloorPortA))
    else $error("port B floor wrong");
  a_driver_enable: assert property (wrEn |-> ##3
    loopDriverOn == ($past(regWdata[3], 3) && loopSourceValid))
    else $error("loop driver enable wrong");
  a_source_agree: assert property (loopSourceB || loopDriverOn |-> loopSourceValid)
    else $error("source or driver without agreeing selects");
  a_field_unused: assert property (wrSelB && regWdata[2] == regWdata[1] |-> ##3
    !loopSourceValid)
    else $error("unused source code accepted");
  a_tx_powerdown: assert property (wrPd |-> ##3 loopTxOff == $past(regWdata[0], 3))
    else $error("transmitter power-down wrong");
  a_pattern_gate: assert property (patternEnable |-> !patternBlocked ##1 loopTxOff)
    else $error("pattern enabled with transmitter up");

  c_bypass: cover property (eqAdaptDisable && eqManualSetting != 6'h00);
  c_floor_b: cover property (wrFlr && secondPortSelect);
  c_driver_on: cover property (loopDriverOn && loopSourceB);
  c_blocked: cover property (patternBlocked);
endmodule : eqlt_config_regs_properties

bind eqlt_config_regs eqlt_config_regs_properties #(.NPORTS(NPORTS)) i_props (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .secondPortSelect(secondPortSelect),
  .eqAdaptDisable(eqAdaptDisable), .eqManualSetting(eqManualSetting),
  .eqFloorPortA(eqFloorPortA), .eqFloorPortB(eqFloorPortB), .loopSourceB(loopSourceB),
  .loopSourceValid(loopSourceValid), .loopDriverOn(loopDriverOn), .loopTxOff(loopTxOff),
  .patternEnable(patternEnable), .patternBlocked(patternBlocked));

`default_nettype wire

// ### sim/eqlt_config_regs_test.sv
// Self-checking bench of the equalizer and loop-through register bank.
`timescale 1ns/1ps
`default_nettype none
`include "eqlt_map.svh"

module eqlt_config_regs_test
  import eqlt_pkg::*;
;
  // One loop-through case: both selects, enable, and {source B, valid, driver on}.
  typedef struct packed {
    logic [7:0] selA;
    logic [7:0] selB;
    logic [7:0] en;
    logic [2:0] out;
  } eqlt_row_t;

  localparam eqlt_row_t ROWS [7] = '{
    '{8'h00, 8'h02, 8'h08, 3'h3}, '{8'h80, 8'h04, 8'h08, 3'h7},
    '{8'h80, 8'h02, 8'h08, 3'h0}, '{8'h00, 8'h00, 8'h08, 3'h0},
    '{8'h80, 8'h04, 8'hF7, 3'h6}, '{8'h7F, 8'h07, 8'h08, 3'h0},
    '{8'h7F, 8'hFB, 8'h08, 3'h3}};
  localparam logic [7:0] RADDR [7] = '{`EQLT_ADDR_EQ_OVERRIDE, `EQLT_ADDR_EQ_FLOOR,
    `EQLT_ADDR_LOOP_SEL_A, `EQLT_ADDR_LOOP_DRV_EN, `EQLT_ADDR_LOOP_SEL_B,
    `EQLT_ADDR_LOOP_TX_PD, `EQLT_ADDR_TEST_PAT};
  localparam logic [7:0] RVAL [7] = '{8'h60, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10};

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic secondPortSelect = 1'b0;
  logic [7:0] regRdata;
  logic eqAdaptDisable;
  logic [5:0] eqManualSetting;
  logic [3:0] eqFloorPortA;
  logic [3:0] eqFloorPortB;
  logic loopSourceB;
  logic loopSourceValid;
  logic loopDriverOn;
  logic loopTxOff;
  logic patternEnable;
  logic patternBlocked;
  int n_errors = 0;
  int samples_checked = 0;

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  eqlt_config_regs #(.NPORTS(2)) i_dut (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .secondPortSelect(secondPortSelect),
    .eqAdaptDisable(eqAdaptDisable), .eqManualSetting(eqManualSetting),
    .eqFloorPortA(eqFloorPortA), .eqFloorPortB(eqFloorPortB), .loopSourceB(loopSourceB),
    .loopSourceValid(loopSourceValid), .loopDriverOn(loopDriverOn), .loopTxOff(loopTxOff),
    .patternEnable(patternEnable), .patternBlocked(patternBlocked));

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, want);
    @(posedge clk);
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  // Holds reset two cycles, then checks every register and every output except patternBlocked at its reset value.
  task automatic reset_and_check();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (RADDR[i]) rd(RADDR[i], RVAL[i]);
    check({eqFloorPortA, eqFloorPortB}, 8'h88);
    check({eqAdaptDisable, eqManualSetting, loopDriverOn}, 8'h00);
    check({loopSourceB, loopSourceValid, loopTxOff, patternEnable}, 8'h00);
    @(posedge clk);
  endtask : reset_and_check

  // Gives up when the sequence hangs.
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence: table of loop-through cases, then the hand-written cases.
  initial begin
    reset_and_check();
    foreach (ROWS[i]) begin
      wr(`EQLT_ADDR_LOOP_SEL_A, ROWS[i].selA);
      wr(`EQLT_ADDR_LOOP_SEL_B, ROWS[i].selB);
      wr(`EQLT_ADDR_LOOP_DRV_EN, ROWS[i].en);
      settle();
      check({loopSourceB, loopSourceValid, loopDriverOn}, {5'h00, ROWS[i].out});
      rd(`EQLT_ADDR_LOOP_SEL_B, ROWS[i].selB);
    end
    wr(`EQLT_ADDR_EQ_OVERRIDE, 8'hB7);
    settle();
    check({eqAdaptDisable, eqManualSetting}, 8'h6B);
    wr(`EQLT_ADDR_EQ_OVERRIDE, 8'hB6);
    settle();
    check({eqAdaptDisable, eqManualSetting}, 8'h00);
    wr(`EQLT_ADDR_EQ_FLOOR, 8'h53);
    secondPortSelect <= 1'b1;
    wr(`EQLT_ADDR_EQ_FLOOR, 8'hAC);
    settle();
    check({eqFloorPortA, eqFloorPortB}, 8'h3C);
    rd(`EQLT_ADDR_EQ_FLOOR, 8'hAC);
    secondPortSelect <= 1'b0;
    rd(`EQLT_ADDR_EQ_FLOOR, 8'h53);
    wr(`EQLT_ADDR_TEST_PAT, 8'h11);
    settle();
    check({patternEnable, patternBlocked, loopTxOff}, 8'h02);
    wr(`EQLT_ADDR_LOOP_TX_PD, 8'h01);
    settle();
    check({patternEnable, patternBlocked, loopTxOff}, 8'h05);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    rd(`EQLT_ADDR_EQ_OVERRIDE, 8'hB6);
    reset_and_check();
    report_and_stop();
  end
endmodule : eqlt_config_regs_test

`default_nettype wire

// ### verilog/eqlt_cfg_if.sv
// Interface joining the register bank to its floor bank and loop-through router.
`timescale 1ns/1ps
`default_nettype none

interface eqlt_cfg_if;
  import eqlt_pkg::*;
  logic floorWr;
  eqlt_byte_t wdata;
  logic portB;
  eqlt_byte_t floorRd;
  logic [3:0] floorA;
  logic [3:0] floorB;
  logic srcBit;
  logic [1:0] srcField;
  logic drvEnable;
  logic txOff;
  eqlt_src_t route;
  logic agree;
  logic drvOn;
  logic txOffOut;

  modport bank (output floorWr, wdata, portB, srcBit, srcField, drvEnable, txOff,
                input floorRd, floorA, floorB, route, agree, drvOn, txOffOut);
  modport floor (input floorWr, wdata, portB, output floorRd, floorA, floorB);
  modport loop (input srcBit, srcField, drvEnable, txOff,
                output route, agree, drvOn, txOffOut);
endinterface : eqlt_cfg_if

`default_nettype wire

// ### verilog/eqlt_config_regs.sv
// Equalizer override, adaptive floor and loop-through configuration register bank.
//
// Overview of operation
// [RQ1] In bypass, equalizer setting bits 5..3 come from override bits 7..5, reset 3.
// [RQ2] In bypass, equalizer setting bits 2..0 come from override bits 3..1, reset 0.
// [RQ3] Adaptation starts from a four-bit floor in bits 3..0, reset 8.
// [RQ4] With second port selected, the floor register serves the second port.
// [RQ5] Single select bit 7: one routes input B, zero routes input A.
// [RQ6] Two-bit select field: code 01 routes input A, code 10 input B.
// [RQ7] Software keeps the select bit and the select field naming one port.
// [RQ8] Loop driver drives only with its enable bit 3 set; resets off.
// [RQ9] Transmitter power-down bit 0: zero powered up, one powered down, reset 0.
// [RQ10] Software powers the transmitter down before starting the pattern generator.
// [RQ11] Bypass bit 0 set applies manual values; clear keeps adaptation running.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eqlt_map.svh"

module eqlt_config_regs
  import eqlt_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic secondPortSelect,
  output logic eqAdaptDisable,
  output logic [5:0] eqManualSetting,
  output logic [3:0] eqFloorPortA,
  output logic [3:0] eqFloorPortB,
  output logic loopSourceB,
  output logic loopSourceValid,
  output logic loopDriverOn,
  output logic loopTxOff,
  output logic patternEnable,
  output logic patternBlocked
);

  eqlt_cfg_if cfg ();

  eqlt_byte_t eqOverride;
  eqlt_byte_t loopSelA;
  eqlt_byte_t loopDrvEn;
  eqlt_byte_t loopSelB;
  eqlt_byte_t loopTxPd;
  eqlt_byte_t testPattern;
  eqlt_byte_t next_rdata;
  logic wrOverride;
  logic wrFloor;
  logic wrSelA;
  logic wrDrvEn;
  logic wrSelB;
  logic wrTxPd;
  logic wrTestPat;
  logic eqBypass;
  logic [2:0] eqHighBits;
  logic [2:0] eqLowBits;
  logic [5:0] next_manual;
  logic txPowerDown;
  logic patternStart;
  logic routeIsB;
  logic next_patternEnable;
  logic next_patternBlocked;

  // Write hits in the equalizer area, one per register.
  assign wrOverride = regWr && (regAddr == `EQLT_ADDR_EQ_OVERRIDE);
  assign wrFloor = regWr && (regAddr == `EQLT_ADDR_EQ_FLOOR);

  // Write hits in the loop-through area.
  assign wrSelA = regWr && (regAddr == `EQLT_ADDR_LOOP_SEL_A);
  assign wrDrvEn = regWr && (regAddr == `EQLT_ADDR_LOOP_DRV_EN);
  assign wrSelB = regWr && (regAddr == `EQLT_ADDR_LOOP_SEL_B);
  assign wrTxPd = regWr && (regAddr == `EQLT_ADDR_LOOP_TX_PD);

  // Write hit of the test pattern byte.
  assign wrTestPat = regWr && (regAddr == `EQLT_ADDR_TEST_PAT);

  // Manual equalizer override byte with the bypass flag in bit 0.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eqOverride <= `EQLT_RST_EQ_OVERRIDE; // RQ1
    end else if (wrOverride) begin
      eqOverride <= regWdata;
    end
  end

  // First loop-through source select, the single bit in position 7.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopSelA <= `EQLT_RST_LOOP_SEL_A;
    end else if (wrSelA) begin
      loopSelA <= regWdata;
    end
  end

  // Loop-through driver enable; the driver stays off until software sets it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopDrvEn <= `EQLT_RST_LOOP_DRV_EN; // RQ8
    end else if (wrDrvEn) begin
      loopDrvEn <= regWdata;
    end
  end

  // Second loop-through source select, the two-bit field.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopSelB <= `EQLT_RST_LOOP_SEL_B;
    end else if (wrSelB) begin
      loopSelB <= regWdata;
    end
  end

  // Loop-through transmitter power-down.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopTxPd <= `EQLT_RST_LOOP_TX_PD; // RQ9
    end else if (wrTxPd) begin
      loopTxPd <= regWdata;
    end
  end

  // Test pattern control byte, held for the pattern generator.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      testPattern <= `EQLT_RST_TEST_PAT;
    end else if (wrTestPat) begin
      testPattern <= regWdata;
    end
  end

  // Controls of the floor bank: write hit, data and the port that it serves.
  assign cfg.floorWr = wrFloor;
  assign cfg.wdata = regWdata;
  assign cfg.portB = secondPortSelect; // RQ4

  // Controls of the router: both source selects, the driver enable and the power-down.
  assign cfg.srcBit = loopSelA[`EQLT_SRC_BIT_POS]; // RQ5
  assign cfg.srcField = loopSelB[`EQLT_SRC_FIELD_MSB:`EQLT_SRC_FIELD_LSB]; // RQ6
  assign cfg.drvEnable = loopDrvEn[`EQLT_DRV_EN_BIT]; // RQ8
  assign cfg.txOff = txPowerDown; // RQ9

  // Named fields of the override, power-down and pattern bytes.
  assign eqBypass = eqOverride[`EQLT_EQ_BYPASS_BIT]; // RQ11
  assign eqHighBits = eqOverride[`EQLT_EQ_HI_MSB:`EQLT_EQ_HI_LSB]; // RQ1
  assign eqLowBits = eqOverride[`EQLT_EQ_LO_MSB:`EQLT_EQ_LO_LSB]; // RQ2
  assign txPowerDown = loopTxPd[`EQLT_TX_PD_BIT]; // RQ9
  assign patternStart = testPattern[`EQLT_PAT_EN_BIT];

  // Manual six-bit setting: both stage fields in bypass, zero while adapting.
  always_comb begin
    if (eqBypass) begin
      next_manual = {eqHighBits, eqLowBits}; // RQ1 RQ2
    end else begin
      next_manual = 6'h00; // RQ11
    end
  end

  eqlt_floor_bank #(
    .NPORTS(NPORTS)
  ) u_floor (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg.floor)
  );

  eqlt_loop_route u_loop (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg.loop)
  );

  // Read multiplexer; an unmapped address reads as zero.
  always_comb begin
    case (regAddr)
      `EQLT_ADDR_EQ_OVERRIDE: next_rdata = eqOverride;
      `EQLT_ADDR_EQ_FLOOR: next_rdata = cfg.floorRd; // RQ4
      `EQLT_ADDR_LOOP_SEL_A: next_rdata = loopSelA;
      `EQLT_ADDR_LOOP_DRV_EN: next_rdata = loopDrvEn;
      `EQLT_ADDR_LOOP_SEL_B: next_rdata = loopSelB;
      `EQLT_ADDR_LOOP_TX_PD: next_rdata = loopTxPd;
      `EQLT_ADDR_TEST_PAT: next_rdata = testPattern;
      default: next_rdata = `EQLT_RD_UNMAPPED;
    endcase
  end

  // Read data stands for the one cycle after the read strobe and is zero otherwise.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= `EQLT_RD_UNMAPPED;
    end else if (regRd) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= `EQLT_RD_UNMAPPED;
    end
  end

  // Bypass level towards the equalizer; a one holds adaptation off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eqAdaptDisable <= 1'b0;
    end else begin
      eqAdaptDisable <= eqBypass; // RQ11
    end
  end

  // Manual equalizer setting handed to the receive front end.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eqManualSetting <= 6'h00;
    end else begin
      eqManualSetting <= next_manual; // RQ1 RQ2
    end
  end

  // Starting floor of port A, registered once more so the output comes from a flop here.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eqFloorPortA <= `EQLT_RST_FLOOR_VALUE;
    end else begin
      eqFloorPortA <= cfg.floorA; // RQ3
    end
  end

  // Starting floor of port B, written only while the second port is selected.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eqFloorPortB <= `EQLT_RST_FLOOR_VALUE;
    end else begin
      eqFloorPortB <= cfg.floorB; // RQ3 RQ4
    end
  end

  // Router decision reduced to the one bit that tells which input feeds the output.
  assign routeIsB = (cfg.route == EQLT_SRC_B); // RQ5

  // Source of the loop-through output.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopSourceB <= 1'b0;
    end else begin
      loopSourceB <= routeIsB; // RQ5
    end
  end

  // Agreement of the two selects; the path stays shut while they differ.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopSourceValid <= 1'b0;
    end else begin
      loopSourceValid <= cfg.agree; // RQ7
    end
  end

  // Loop-through driver, on only with its enable set and the selects agreeing.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopDriverOn <= 1'b0;
    end else begin
      loopDriverOn <= cfg.drvOn; // RQ8
    end
  end

  // Transmitter power-down level.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loopTxOff <= 1'b0;
    end else begin
      loopTxOff <= cfg.txOffOut; // RQ9
    end
  end

  // Pattern start is let through only once the transmitter is powered down.
  assign next_patternEnable = patternStart && txPowerDown; // RQ10
  assign next_patternBlocked = patternStart && !txPowerDown; // RQ10

  // Pattern generator enable towards the generator.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      patternEnable <= 1'b0;
    end else begin
      patternEnable <= next_patternEnable; // RQ10
    end
  end

  // Flag of a start request made while the transmitter is still powered.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      patternBlocked <= 1'b0;
    end else begin
      patternBlocked <= next_patternBlocked; // RQ10
    end
  end

endmodule : eqlt_config_regs

`default_nettype wire

// ### verilog/eqlt_floor_bank.sv
// Per-port adaptive equalizer floor registers, written and read through the port select.
`timescale 1ns/1ps
`default_nettype none
`include "eqlt_map.svh"

module eqlt_floor_bank
  import eqlt_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic clk,
  input wire logic rstn,
  eqlt_cfg_if.floor cfg
);

  eqlt_byte_t floorReg [NPORTS];

  // One floor byte per receive port; a write lands on the port chosen by the select.
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        floorReg[p] <= `EQLT_RST_EQ_FLOOR;
      end else if (cfg.floorWr && (int'(cfg.portB) == p)) begin
        floorReg[p] <= cfg.wdata; // RQ4
      end
    end
  end

  // Readback shows the byte of the currently selected port.
  assign cfg.floorRd = floorReg[cfg.portB]; // RQ4
  // Starting floor handed to each port's adaptation engine.
  assign cfg.floorA = floorReg[0][`EQLT_FLOOR_MSB:`EQLT_FLOOR_LSB]; // RQ3
  assign cfg.floorB = floorReg[1][`EQLT_FLOOR_MSB:`EQLT_FLOOR_LSB]; // RQ3

endmodule : eqlt_floor_bank

`default_nettype wire

// ### verilog/eqlt_loop_route.sv
// Resolves the loop-through source from both select registers and drives the output controls.
`timescale 1ns/1ps
`default_nettype none
`include "eqlt_map.svh"

module eqlt_loop_route
  import eqlt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  eqlt_cfg_if.loop cfg
);

  eqlt_src_t next_route;
  logic next_agree;
  eqlt_src_t fieldSrc;

  // Decode of the two-bit field; codes 00 and 11 name no port.
  always_comb begin
    case (cfg.srcField)
      `EQLT_SRC_CODE_A: fieldSrc = EQLT_SRC_A; // RQ6
      `EQLT_SRC_CODE_B: fieldSrc = EQLT_SRC_B; // RQ6
      default: fieldSrc = EQLT_SRC_NONE;
    endcase
  end

  // The single bit picks the port; the field must name the same one for the path to open.
  always_comb begin
    next_agree = (fieldSrc == (cfg.srcBit ? EQLT_SRC_B : EQLT_SRC_A)); // RQ7
    next_route = next_agree ? fieldSrc : EQLT_SRC_NONE;
    if (next_agree) begin
      next_route = cfg.srcBit ? EQLT_SRC_B : EQLT_SRC_A; // RQ5
    end
  end

  // Registered controls so the analog side sees clean levels.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg.route <= EQLT_SRC_NONE;
      cfg.agree <= 1'b0;
      cfg.drvOn <= 1'b0;
      cfg.txOffOut <= 1'b0;
    end else begin
      cfg.route <= next_route;
      cfg.agree <= next_agree;
      cfg.drvOn <= cfg.drvEnable && next_agree; // RQ8
      cfg.txOffOut <= cfg.txOff; // RQ9
    end
  end

endmodule : eqlt_loop_route

`default_nettype wire

// ### verilog/eqlt_map.svh
// Register offsets, field positions and reset values of the equalizer and loop-through bank.
`ifndef EQLT_MAP_SVH
`define EQLT_MAP_SVH

`define EQLT_ADDR_EQ_OVERRIDE 8'h44
`define EQLT_ADDR_EQ_FLOOR 8'h45
`define EQLT_ADDR_LOOP_SEL_A 8'h52
`define EQLT_ADDR_LOOP_DRV_EN 8'h56
`define EQLT_ADDR_LOOP_SEL_B 8'h57
`define EQLT_ADDR_LOOP_TX_PD 8'h63
`define EQLT_ADDR_TEST_PAT 8'h64

`define EQLT_RST_EQ_OVERRIDE 8'h60
`define EQLT_RST_EQ_FLOOR 8'h88
`define EQLT_RST_LOOP_SEL_A 8'h00
`define EQLT_RST_LOOP_DRV_EN 8'h00
`define EQLT_RST_LOOP_SEL_B 8'h00
`define EQLT_RST_LOOP_TX_PD 8'h00
`define EQLT_RST_TEST_PAT 8'h10
`define EQLT_RD_UNMAPPED 8'h00

`define EQLT_EQ_HI_MSB 7
`define EQLT_EQ_HI_LSB 5
`define EQLT_EQ_LO_MSB 3
`define EQLT_EQ_LO_LSB 1
`define EQLT_EQ_BYPASS_BIT 0
`define EQLT_FLOOR_MSB 3
`define EQLT_FLOOR_LSB 0
`define EQLT_SRC_BIT_POS 7
`define EQLT_SRC_FIELD_MSB 2
`define EQLT_SRC_FIELD_LSB 1
`define EQLT_DRV_EN_BIT 3
`define EQLT_TX_PD_BIT 0
`define EQLT_PAT_EN_BIT 0
`define EQLT_RST_FLOOR_VALUE 4'h8

`define EQLT_SRC_CODE_A 2'h1
`define EQLT_SRC_CODE_B 2'h2

`endif

// ### verilog/eqlt_pkg.sv
// Types shared by the equalizer and loop-through configuration bank.
package eqlt_pkg;

  typedef logic [7:0] eqlt_byte_t;

  // Receive input that feeds the loop-through output.
  typedef enum logic [1:0] {
    EQLT_SRC_NONE,
    EQLT_SRC_A,
    EQLT_SRC_B
  } eqlt_src_t;

endpackage : eqlt_pkg
